/* hdl/analog_pin_mux_group2.sv */
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
// second analog pin multiplexer group with apb register access
// Summary of operation
// RQ1: after reset all ten pins are routed to analog and digital drive is off.
// RQ2: a cleared odd select bit puts its pin in digital mode on its digital signal.
// RQ3: a set odd select bit routes the pin to its converter and comparator input.
// RQ4: even bits of the mode select register do not affect routing.
// RQ5: bit 9 selects between digital signal 20 and converter a4 or comparator a5.
// RQ6: digital mode maps a2 to signal 18, a6 to 22 and b4 to 28; analog shares comparators.
// RQ7: converter inputs a0 a3 a7 b0 b3 b7 have no digital function.
// RQ8: only the control processor may read or write these registers.
// RQ9: each of the four digital bits is readable, writable and has its own direction.
// RQ10: the digital path offers no pull-up.
// RQ11: this group has its own register set apart from the first group.
// RQ12: software enables only one of converter or comparator on a shared pin; here one select bit enables both routes together.
// RQ13: only the digital and analog modes exist; no peripheral modes.
// RQ14: select bits are 5 for a2, 9 for a4, 13 for a6 and 25 for b4.
// RQ15: in analog mode the digital driver is off and data reads ignore the pin.
module analog_pin_mux_group2 (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        pmaster_ctrl,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic [3:0]  dig_pad_in,
  output logic [3:0]       dig_pad_out,
  output logic [3:0]       dig_pad_oe,
  output logic [3:0]       dig_pull_en,
  output logic [9:0]       conv2_route_en,
  output logic [3:0]       comparator_route_en
);

  localparam int unsigned SEL_BIT [4] = '{pin_mux2_pkg::SEL_BIT_A2,
                                          pin_mux2_pkg::SEL_BIT_A4,
                                          pin_mux2_pkg::SEL_BIT_A6,
                                          pin_mux2_pkg::SEL_BIT_B4};
  localparam int unsigned PIN_IDX [4] = '{pin_mux2_pkg::PIN_A2,
                                          pin_mux2_pkg::PIN_A4,
                                          pin_mux2_pkg::PIN_A6,
                                          pin_mux2_pkg::PIN_B4};

  initial begin
    if (pin_mux2_pkg::NUM_DIG != 4 || pin_mux2_pkg::NUM_PINS != 10) begin
      $error("pin group shape not supported");
    end
  end

  logic [31:0] pin_mode_select_reg_r;
  logic [3:0]  dig_data_r;
  logic [3:0]  dig_dir_r;
  logic [3:0]  analog_sel;
  logic [3:0]  pad_seen;
  logic [3:0]  analog_en;
  logic        wr_ok;
  logic        rd_ok;
  logic        access;
  logic        xfer_end;
  logic [31:0] rd_nxt;
  logic        err_nxt;

  // decodes a register offset; used for both read and write paths
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == pin_mux2_pkg::MODE_SEL_OFS) || (a == pin_mux2_pkg::DATA_OFS) ||
             (a == pin_mux2_pkg::DIR_OFS) || (a == pin_mux2_pkg::SET_OFS) ||
             (a == pin_mux2_pkg::CLR_OFS) || (a == pin_mux2_pkg::TOGGLE_OFS) ||
             (a == pin_mux2_pkg::STATUS_OFS);
  endfunction

  // single-wait answer: the access phase finishes at the edge where pready is seen
  assign access = psel & penable & ~pready;
  // writes land only at the edge where the master sees pready
  assign xfer_end = psel & penable & pready;
  // RQ8 control processor only
  assign wr_ok  = xfer_end & pwrite & pmaster_ctrl & mapped(paddr);
  assign rd_ok  = access & ~pwrite & pmaster_ctrl & mapped(paddr);

  // RQ11 own register set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_mode_select_reg_r <= pin_mux2_pkg::MODE_SEL_RST;
    end else if (wr_ok && paddr == pin_mux2_pkg::MODE_SEL_OFS) begin
      pin_mode_select_reg_r <= pwdata;
    end
  end

  // RQ9 data bit writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dig_data_r <= pin_mux2_pkg::DATA_RST[3:0];
    end else if (wr_ok) begin
      unique case (paddr)
        pin_mux2_pkg::DATA_OFS:   dig_data_r <= pwdata[3:0];
        pin_mux2_pkg::SET_OFS:    dig_data_r <= dig_data_r | pwdata[3:0];
        pin_mux2_pkg::CLR_OFS:    dig_data_r <= dig_data_r & ~pwdata[3:0];
        pin_mux2_pkg::TOGGLE_OFS: dig_data_r <= dig_data_r ^ pwdata[3:0];
        default:                  dig_data_r <= dig_data_r;
      endcase
    end
  end

  // RQ9 per-bit direction
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dig_dir_r <= pin_mux2_pkg::DIR_RST[3:0];
    end else if (wr_ok && paddr == pin_mux2_pkg::DIR_OFS) begin
      dig_dir_r <= pwdata[3:0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dig
      // RQ4 odd bits only
      // RQ14 select bit pattern
      // RQ2 clear bit digital
      // RQ13 two modes only
      assign analog_sel[g] = pin_mode_select_reg_r[SEL_BIT[g]];
      dig_pin_cell u_cell (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .analog_sel(analog_sel[g]),
        .dir_out   (dig_dir_r[g]),
        .data_out  (dig_data_r[g]),
        .pad_in    (dig_pad_in[g]),
        .pad_out   (dig_pad_out[g]),
        .pad_oe    (dig_pad_oe[g]),
        .pad_seen  (pad_seen[g]),
        .analog_en (analog_en[g])
      );
    end
  endgenerate

  // RQ10 no pull-up
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dig_pull_en <= 4'h0;
    end else begin
      dig_pull_en <= 4'h0;
    end
  end

  // RQ5 bit 9 routes a4
  // RQ6 analog side shared
  // RQ7 analog-only pins
  // RQ1 analog after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv2_route_en      <= 10'h3ff;
      comparator_route_en <= 4'hf;
    end else begin
      for (int i = 0; i < 10; i++) begin
        conv2_route_en[i] <= 1'b1;
      end
      for (int k = 0; k < 4; k++) begin
        conv2_route_en[PIN_IDX[k]] <= analog_en[k];
        comparator_route_en[k]     <= analog_en[k];
      end
    end
  end

  always_comb begin
    rd_nxt  = pin_mux2_pkg::UNMAPPED_RD;
    err_nxt = 1'b0;
    if (access && !mapped(paddr)) begin
      err_nxt = 1'b1;
    end
    if (rd_ok) begin
      unique case (paddr)
        pin_mux2_pkg::MODE_SEL_OFS: rd_nxt = pin_mode_select_reg_r;
        // RQ15 pin hidden in analog
        pin_mux2_pkg::DATA_OFS:     rd_nxt = {28'h0000000, pad_seen};
        pin_mux2_pkg::DIR_OFS:      rd_nxt = {28'h0000000, dig_dir_r};
        pin_mux2_pkg::STATUS_OFS: begin
          rd_nxt[pin_mux2_pkg::ST_PIN_LSB +: 4]  = dig_data_r;
          rd_nxt[pin_mux2_pkg::ST_MODE_LSB +: 4] = analog_sel;
        end
        default:                    rd_nxt = pin_mux2_pkg::UNMAPPED_RD;
      endcase
    end
  end

  // one wait state keeps prdata registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access;
      pslverr <= err_nxt;
      prdata  <= rd_nxt;
    end
  end

endmodule

/* hdl/pin_mux2_pkg.sv */
// constants for the second analog pin multiplexer group
package pin_mux2_pkg;
  // register byte offsets
  localparam logic [11:0] MODE_SEL_OFS = 12'h000;
  localparam logic [11:0] DATA_OFS     = 12'h004;
  localparam logic [11:0] DIR_OFS      = 12'h008;
  localparam logic [11:0] SET_OFS      = 12'h00c;
  localparam logic [11:0] CLR_OFS      = 12'h010;
  localparam logic [11:0] TOGGLE_OFS   = 12'h014;
  localparam logic [11:0] STATUS_OFS   = 12'h018;
  // number of pins in the group
  localparam int unsigned NUM_PINS     = 10;
  // digital-capable pins
  localparam int unsigned NUM_DIG      = 4;
  // reset: every odd bit set, so all pins are analog
  localparam logic [31:0] MODE_SEL_RST = 32'haaaaaaaa;
  localparam logic [31:0] DATA_RST     = 32'h00000000;
  localparam logic [31:0] DIR_RST      = 32'h00000000;
  // select bit positions of the four digital-capable pins (a2, a4, a6, b4)
  localparam int unsigned SEL_BIT_A2   = 5;
  localparam int unsigned SEL_BIT_A4   = 9;
  localparam int unsigned SEL_BIT_A6   = 13;
  localparam int unsigned SEL_BIT_B4   = 25;
  // pin index of each digital-capable pin in the group order a0 a2 a3 a4 a6 a7 b0 b3 b4 b7
  localparam int unsigned PIN_A2       = 1;
  localparam int unsigned PIN_A4       = 3;
  localparam int unsigned PIN_A6       = 4;
  localparam int unsigned PIN_B4       = 8;
  // bits of the status register
  localparam int unsigned ST_PIN_LSB   = 0;
  localparam int unsigned ST_MODE_LSB  = 4;
  // value driven on an unmapped read
  localparam logic [31:0] UNMAPPED_RD  = 32'h00000000;
endpackage

/* hdl/dig_pin_cell.sv */
`timescale 1ns/1ps
// one digital-capable pin: direction, output drive and input qualification
module dig_pin_cell (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic analog_sel,
  input  wire logic dir_out,
  input  wire logic data_out,
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_seen,
  output logic      analog_en
);

  // RQ15 driver off in analog
  // follows analog_en, so the driver and the converter route switch on one edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pad_oe  <= 1'b0;
      pad_out <= 1'b0;
    end else begin
      pad_oe  <= ~analog_en & dir_out;
      pad_out <= ~analog_en & data_out;
    end
  end

  // RQ15 input masked in analog
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pad_seen <= 1'b0;
    end else begin
      pad_seen <= ~analog_en & (dir_out ? data_out : pad_in);
    end
  end

  // RQ3 analog path follows select
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      analog_en <= 1'b1;
    end else begin
      analog_en <= analog_sel;
    end
  end

endmodule

/* testbench/pin_mux2_assertions.sv */
// port-level checks for the second analog pin mux group
`timescale 1ns/1ps
module pin_mux2_assertions (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pmaster_ctrl,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [3:0]  dig_pad_oe,
  input wire logic [3:0]  dig_pull_en,
  input wire logic [9:0]  conv2_route_en,
  input wire logic [3:0]  comparator_route_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [3:0] dsel;
  logic [3:0] wsel;
  logic       take;
  assign dsel = {conv2_route_en[8], conv2_route_en[4], conv2_route_en[3], conv2_route_en[1]};
  assign wsel = {pwdata[25], pwdata[13], pwdata[9], pwdata[5]};
  assign take = psel && penable && !pready;
  reset_route_a: assert property ($rose(rst_n) |->
    conv2_route_en == 10'h3ff && dig_pad_oe == 4'h0) else $error("pins not analog after reset");
  mode_write_a: assert property (take && pwrite && pmaster_ctrl && paddr == 12'h000 |=>
    ##3 dsel == $past(wsel, 4)) else $error("routing does not follow odd select bits");
  fixed_analog_a: assert property ((conv2_route_en & 10'h2e5) == 10'h2e5)
    else $error("analog-only pin lost its route");
  comp_share_a: assert property (comparator_route_en == dsel)
    else $error("comparator route differs from converter route");
  pull_off_a: assert property (dig_pull_en == 4'h0) else $error("pull-up enabled");
  oe_analog_a: assert property ((dig_pad_oe & dsel) == 4'h0)
    else $error("pad driven while in analog mode");
  other_cpu_a: assert property (take && !pmaster_ctrl |=>
    prdata == 32'h0 && !pslverr ##1 $stable(conv2_route_en)) else $error("other cpu had effect");
  ready_wait_a: assert property (take |=> pready) else $error("answer not after one wait");
  cover property (take && pwrite && pmaster_ctrl);
  cover property (take && !pmaster_ctrl);
  cover property (pslverr);
  cover property (dig_pad_oe == 4'hf);
endmodule

/* testbench/pad_partner.sv */
// pin side model: outside source or a floating level on the digital pins
`timescale 1ns/1ps
module pad_partner (
  input  wire logic [3:0] dig_pad_out,
  input  wire logic [3:0] dig_pad_oe,
  input  wire logic [3:0] ext_val,
  input  wire logic [3:0] ext_oe,
  input  wire logic       mclk,
  output logic      [3:0] dig_pad_in
);
  logic [3:0] float_r = 4'h5;
  // no pull-up
  // nobody drives the pin: show a level that flips every cycle
  always_ff @(posedge mclk) float_r <= ~float_r;
  assign dig_pad_in = (dig_pad_oe & dig_pad_out) | (~dig_pad_oe & ext_oe & ext_val)
                    | (~dig_pad_oe & ~ext_oe & float_r);
endmodule

/* testbench/analog_pin_mux_group2_tb.sv */
// self-checking bench for the second analog pin mux group
`timescale 1ns/1ps
module analog_pin_mux_group2_tb;
  logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pmaster_ctrl = 1'b1, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [3:0]  ext_val = 4'h0, ext_oe = 4'h0, dig_pad_in, dig_pad_out, dig_pad_oe, dig_pull_en;
  logic [3:0]  comparator_route_en;
  logic [9:0]  conv2_route_en;
  int          failures = 0, samples_checked = 0;
  int          sb[4] = '{5, 9, 13, 25};
  int          pn[4] = '{1, 3, 4, 8};
  analog_pin_mux_group2 dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pmaster_ctrl, .pready, .pslverr, .prdata, .dig_pad_in, .dig_pad_out, .dig_pad_oe,
    .dig_pull_en, .conv2_route_en, .comparator_route_en);
  pad_partner pad (.mclk, .dig_pad_out, .dig_pad_oe, .ext_val, .ext_oe, .dig_pad_in);
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] x);
    samples_checked++;
    if (got !== x) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, x, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic c);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pmaster_ctrl <= c;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    err = pslverr;
    chk("pready", 32'(pready), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic c);
    apb(1'b0, a, 32'h0, c);
    chk("prdata", rdv, x);
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk);
  endtask
  task automatic summarize;
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    forever #10 mclk = ~mclk;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    failures++;
    $display("[ERR] run expected done seen hang");
    summarize();
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(12'h000, 32'haaaaaaaa, 1'b1);
    chk("route", 32'(conv2_route_en), 32'h3ff);
    // bench expects converter and comparator routes to switch together on each pin
    for (int i = 0; i < 4; i++) begin
      // even bits all set on purpose, they must not matter
      apb(1'b1, 12'h000, 32'h55555555 | (32'haaaaaaaa & ~(32'h1 << sb[i])), 1'b1);
      settle();
      chk("route", 32'(conv2_route_en), 32'h3ff & ~(32'h1 << pn[i]));
      chk("comp", 32'(comparator_route_en), 32'hf & ~(32'h1 << i));
    end
    apb(1'b1, 12'h000, 32'h0, 1'b1);
    apb(1'b1, 12'h008, 32'hf, 1'b1);
    apb(1'b1, 12'h004, 32'ha, 1'b1);
    settle();
    chk("oe", 32'(dig_pad_oe), 32'hf);
    chk("out", 32'(dig_pad_out), 32'ha);
    chk("route", 32'(conv2_route_en), 32'h2e5);
    rd(12'h004, 32'ha, 1'b1);
    ext_oe <= 4'hf;
    ext_val <= 4'h5;
    apb(1'b1, 12'h008, 32'h0, 1'b1);
    settle();
    rd(12'h004, 32'h5, 1'b1);
    apb(1'b1, 12'h000, 32'haaaaaaaa, 1'b1);
    apb(1'b1, 12'h008, 32'hf, 1'b1);
    settle();
    chk("oe", 32'(dig_pad_oe), 32'h0);
    rd(12'h004, 32'h0, 1'b1);
    apb(1'b1, 12'h000, 32'h0, 1'b0);
    settle();
    chk("route", 32'(conv2_route_en), 32'h3ff);
    rd(12'h000, 32'h0, 1'b0);
    rd(12'h000, 32'haaaaaaaa, 1'b1);
    apb(1'b1, 12'h01c, 32'h0, 1'b1);
    chk("pslverr", 32'(err), 32'h1);
    summarize();
  end
endmodule
bind analog_pin_mux_group2 pin_mux2_assertions chk_i (.mclk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pmaster_ctrl, .pready, .pslverr, .prdata, .dig_pad_oe, .dig_pull_en,
  .conv2_route_en, .comparator_route_en);
